// file: hw/global_ctl_consts.svh
// constants for the global flop-init and output-float control block
`ifndef GLOBAL_CTL_CONSTS_SVH
`define GLOBAL_CTL_CONSTS_SVH
`define ADDR_CTRL        8'h00
`define ADDR_STATUS      8'h04
`define ADDR_FLOP_CFG    8'h08
`define ADDR_FLOP_STATE  8'h0c
`define ADDR_LOCAL_CLR   8'h10
`define ADDR_MEM_INIT    8'h14
`define ADDR_MEM_ADDR    8'h18
`define ADDR_MEM_DATA    8'h1c
`define ADDR_OUT_DATA    8'h20
`define ADDR_SCAN_DATA   8'h24
`define CTRL_INIT_SRC    8
`define CTRL_INIT_INV    7
`define CTRL_INIT_SOFT   6
`define CTRL_FLT_SRC     5
`define CTRL_FLT_INV     4
`define CTRL_FLT_SOFT    3
`define CTRL_SCAN_EN     2
`define CTRL_EXTEST      1
`define CTRL_CONFIG      0
`define CTRL_RESET       9'h000
`define NUM_FLOPS        8
`define NUM_OUTS         8
`define MEM_DEPTH        16
`define MEM_AW           4
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10
`endif

// file: hw/global_ctl_pkg.sv
// types for the global flop-init and output-float control block
package global_ctl_pkg;
   typedef struct packed {
      logic init_src;
      logic init_inv;
      logic init_soft;
      logic flt_src;
      logic flt_inv;
      logic flt_soft;
      logic scan_en;
      logic extest;
      logic config_mode;
   } ctrl_s;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WRESP = 3'b010,
      ST_RDATA = 3'b100
   } bus_state_e;
endpackage

// file: hw/global_set_reset_and_float.sv
// global flop-init and output-float control with a small flop bank, memory and output pins
// Behaviour
// - every flop goes to its configured set or clear value at power-up, at configuration and while flop-init is on.
// - a flop answers flop-init just as its local set/clear: set-configured flops set, clear-configured flops clear.
// - flop-init may be taken from a user input pin.
// - the pin source for flop-init may be inverted, giving active high or active low sense.
// - flop-init may instead come from an internal node.
// - while output-float is on, every output pin is released to high impedance.
// - with scan enabled and the external-test instruction active, output-float is ignored and outputs follow scan data.
// - output-float may be taken from a user input pin.
// - the pin source for output-float may be inverted, giving active high or active low sense.
// - output-float may instead come from an internal node.
// - flop-init leaves the memory contents untouched.
// - memory initial contents load only while configuration is in progress.
// - memory with no initial contents given is filled with zero at configuration.
// - a memory write happens at the clock edge while write enable is high; write enable is active high only.
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "global_ctl_consts.svh"
module global_set_reset_and_float
   import global_ctl_pkg::*;
(
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic                   init_pin,
   input  wire logic                   float_pin,
   input  wire logic                   user_node,
   input  wire logic [`NUM_FLOPS-1:0]  flop_d,
   input  wire logic                   mem_we,
   input  wire logic [`MEM_AW-1:0]     mem_waddr,
   input  wire logic                   mem_wdata,
   input  wire logic [`MEM_AW-1:0]     mem_raddr,
   output logic                        mem_rdata,
   output logic [`NUM_FLOPS-1:0]       flop_q,
   output logic [`NUM_OUTS-1:0]        pin_out,
   output logic [`NUM_OUTS-1:0]        pin_oe,
   output logic                        flop_init_active,
   output logic                        float_active,
   input  wire logic [7:0]             s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [7:0]             s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready
);
   ctrl_s                   ctrl;
   logic [`NUM_FLOPS-1:0]   flop_cfg;
   logic [`NUM_FLOPS-1:0]   local_clr;
   logic [`MEM_DEPTH-1:0]   mem_init;
   logic [`MEM_DEPTH-1:0]   mem;
   logic [`NUM_OUTS-1:0]    out_data;
   logic [`NUM_OUTS-1:0]    scan_data;
   logic                    cfg_done;
   bus_state_e              bstate;
   logic [7:0]              aw_addr;
   logic                    aw_held;
   logic [31:0]             w_data;
   logic [3:0]              w_strb;
   logic                    w_held;
   logic                    wr_fire;
   logic                    wr_ok;
   logic                    flop_init;
   logic                    out_float;
   logic                    extest_on;
   logic [31:0]             cur_word;
   logic [31:0]             new_word;

   // choose pin or node, then optional inversion of the pin sense
   function automatic logic pick_src(input logic use_node, input logic inv, input logic pin, input logic node);
      pick_src = use_node ? node : (pin ^ inv);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      merge = r;
   endfunction

   function automatic logic known_addr(input logic [7:0] a);
      known_addr = (a <= `ADDR_SCAN_DATA) && (a[1:0] == 2'b00);
   endfunction

   // flop-init source
   // a software bit adds an on-demand request on top of the chosen source
   assign flop_init = pick_src(ctrl.init_src, ctrl.init_inv, init_pin, user_node) | ctrl.init_soft
                      | ctrl.config_mode;
   assign out_float = pick_src(ctrl.flt_src, ctrl.flt_inv, float_pin, user_node) | ctrl.flt_soft;
   assign extest_on = ctrl.scan_en & ctrl.extest;

   assign wr_fire = aw_held & w_held & (bstate == ST_IDLE);
   assign wr_ok   = known_addr(aw_addr);

   // current image of the addressed register, so byte strobes keep the lanes not written
   always_comb begin
      case (aw_addr)
         `ADDR_CTRL:      cur_word = {23'h000000, ctrl};
         `ADDR_FLOP_CFG:  cur_word = {24'h000000, flop_cfg};
         `ADDR_LOCAL_CLR: cur_word = {24'h000000, local_clr};
         `ADDR_MEM_INIT:  cur_word = {16'h0000, mem_init};
         `ADDR_OUT_DATA:  cur_word = {24'h000000, out_data};
         `ADDR_SCAN_DATA: cur_word = {24'h000000, scan_data};
         default:         cur_word = 32'h00000000;
      endcase
   end
   // bits above a register's width are cut off at the write below
   assign new_word = merge(cur_word, w_data, w_strb);

   // write address and data are taken independently, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
      end else begin
         s_axi_awready <= !(aw_held || (s_axi_awvalid && s_axi_awready)) || wr_fire;
         s_axi_wready  <= !(w_held || (s_axi_wvalid && s_axi_wready)) || wr_fire;
      end
   end

   // response channels; one shared state machine, so one write or one read in flight at most, never both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bstate        <= ST_IDLE;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= `RESP_OKAY;
         s_axi_rdata   <= 32'h00000000;
      end else begin
         s_axi_arready <= 1'b0;
         case (bstate)
            ST_IDLE: begin
               if (wr_fire) begin
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
                  bstate       <= ST_WRESP;
               end else if (s_axi_arvalid) begin
                  s_axi_arready <= 1'b1;
                  s_axi_rvalid  <= 1'b1;
                  s_axi_rresp   <= known_addr(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
                  case (s_axi_araddr)
                     `ADDR_CTRL:       s_axi_rdata <= {23'h000000, ctrl};
                     `ADDR_STATUS:     s_axi_rdata <= {29'h00000000, extest_on, out_float, flop_init};
                     `ADDR_FLOP_CFG:   s_axi_rdata <= {24'h000000, flop_cfg};
                     `ADDR_FLOP_STATE: s_axi_rdata <= {24'h000000, flop_q};
                     `ADDR_LOCAL_CLR:  s_axi_rdata <= {24'h000000, local_clr};
                     `ADDR_MEM_INIT:   s_axi_rdata <= {16'h0000, mem_init};
                     `ADDR_MEM_DATA:   s_axi_rdata <= {16'h0000, mem};
                     `ADDR_OUT_DATA:   s_axi_rdata <= {24'h000000, out_data};
                     `ADDR_SCAN_DATA:  s_axi_rdata <= {24'h000000, scan_data};
                     default:          s_axi_rdata <= 32'h00000000;
                  endcase
                  bstate <= ST_RDATA;
               end
            end
            ST_WRESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  bstate       <= ST_IDLE;
               end
            end
            ST_RDATA: begin
               if (s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  bstate       <= ST_IDLE;
               end
            end
            default: begin
               bstate <= ST_IDLE;
            end
         endcase
      end
   end

   // software registers; unmapped or read-only writes are dropped
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl      <= `CTRL_RESET;
         flop_cfg  <= 8'h00;
         local_clr <= 8'h00;
         mem_init  <= 16'h0000;
         out_data  <= 8'h00;
         scan_data <= 8'h00;
      end else if (wr_fire) begin
         case (aw_addr)
            `ADDR_CTRL:      ctrl      <= ctrl_s'(new_word[8:0]);
            `ADDR_FLOP_CFG:  flop_cfg  <= new_word[7:0];
            `ADDR_LOCAL_CLR: local_clr <= new_word[7:0];
            `ADDR_MEM_INIT:  mem_init  <= new_word[15:0];
            `ADDR_OUT_DATA:  out_data  <= new_word[7:0];
            `ADDR_SCAN_DATA: scan_data <= new_word[7:0];
            default: ;
         endcase
      end
   end

   // the flop bank; a flop's configured value is its flop_cfg bit
   // aresetn stands for power-up; the global net is sampled each edge since all logic here is one clock
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flop_q <= 8'h00;
         cfg_done <= 1'b0;
      end else begin
         cfg_done <= 1'b1;
         for (int i = 0; i < `NUM_FLOPS; i++) begin
            if (flop_init || local_clr[i] || !cfg_done) begin
               flop_q[i] <= flop_cfg[i];
            end else begin
               flop_q[i] <= flop_d[i];
            end
         end
      end
   end

   // memory: no reset path, so flop-init cannot reach it
   always_ff @(posedge aclk) begin
      if (ctrl.config_mode) begin
         mem <= mem_init;
      // write on edge with we high
      end else if (mem_we) begin
         mem[mem_waddr] <= mem_wdata;
      end
   end

   // registered read port: one cycle of latency traded for an output straight from a flop
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mem_rdata <= 1'b0;
      end else begin
         mem_rdata <= mem[mem_raddr];
      end
   end

   // output pins
   // a floating pin keeps out_data on its driver, so re-enabling it shows no stale value
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out          <= 8'h00;
         pin_oe           <= 8'h00;
         flop_init_active <= 1'b0;
         float_active     <= 1'b0;
      end else begin
         flop_init_active <= flop_init;
         float_active     <= out_float & !extest_on;
         if (extest_on) begin
            pin_out <= scan_data;
            pin_oe  <= 8'hff;
         end else if (out_float) begin
            pin_out <= out_data;
            pin_oe  <= 8'h00;
         end else begin
            pin_out <= out_data;
            pin_oe  <= 8'hff;
         end
      end
   end
endmodule

// file: bench/pad_load.sv
// far-side model of the output pads with a pull-down on each pin
`timescale 1ns/1ps
module pad_load (
   input  wire logic [7:0] drv,
   input  wire logic [7:0] oe,
   output logic      [7:0] pad
);
   // a released pin sinks to the pull-down, never keeps its last driven level
   always_comb pad = drv & oe;
endmodule

// file: bench/global_ctl_checker.sv
// port assertions for the global flop-init and output-float block
`timescale 1ns/1ps
`include "global_ctl_consts.svh"
module global_ctl_checker (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        mem_we,
   input wire logic [3:0]  mem_waddr,
   input wire logic        mem_wdata,
   input wire logic [3:0]  mem_raddr,
   input wire logic        mem_rdata,
   input wire logic [7:0]  flop_q,
   input wire logic [7:0]  pin_oe,
   input wire logic        flop_init_active,
   input wire logic        float_active,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_aw_taken; s_axi_awvalid && s_axi_awready; endsequence
   sequence s_mem_wr_rd; mem_we ##1 (!mem_we && mem_raddr == $past(mem_waddr)); endsequence
   property p_float_release; float_active && $past(float_active) |-> pin_oe == 8'h00; endproperty
   a_float_release: assert property (p_float_release) else $error("outputs driven while floating");
   property p_init_hold; flop_init_active [*3] |-> $stable(flop_q); endproperty
   a_init_hold: assert property (p_init_hold) else $error("flops moved during flop-init");
   property p_mem_write; s_mem_wr_rd |=> mem_rdata == $past(mem_wdata, 2); endproperty
   a_mem_write: assert property (p_mem_write) else $error("memory write not seen on read");
   property p_b_after_aw; s_aw_taken |-> ##[1:20] s_axi_bvalid; endproperty
   a_b_after_aw: assert property (p_b_after_aw) else $error("write response missing");
   property p_bvalid_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");
   property p_rvalid_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped");
   property p_ar_with_r; s_axi_arready |-> s_axi_rvalid; endproperty
   a_ar_with_r: assert property (p_ar_with_r) else $error("arready without rvalid");
   property p_resp_code; s_axi_bvalid |-> s_axi_bresp inside {`RESP_OKAY, `RESP_SLVERR}; endproperty
   a_resp_code: assert property (p_resp_code) else $error("bad write response code");
endmodule
bind global_set_reset_and_float global_ctl_checker chk (
   .aclk(aclk), .aresetn(aresetn), .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata),
   .mem_raddr(mem_raddr), .mem_rdata(mem_rdata), .flop_q(flop_q), .pin_oe(pin_oe),
   .flop_init_active(flop_init_active), .float_active(float_active), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// file: bench/test_global_set_reset_and_float.sv
// self-checking bench for the global flop-init and output-float block
`timescale 1ns/1ps
`include "global_ctl_consts.svh"
module test_global_set_reset_and_float import global_ctl_pkg::*;;
   logic        aclk, aresetn, init_pin, float_pin, user_node, mem_we, mem_wdata, mem_rdata;
   logic        flop_init_active, float_active, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [3:0]  mem_waddr, mem_raddr, s_axi_wstrb;
   logic [7:0]  flop_d, flop_q, pin_out, pin_oe, pad, s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [13:0] tbl [10];
   int          error_cnt, total_checks;
   global_set_reset_and_float DUT (
      .aclk(aclk), .aresetn(aresetn), .init_pin(init_pin), .float_pin(float_pin), .user_node(user_node),
      .flop_d(flop_d), .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .mem_raddr(mem_raddr),
      .mem_rdata(mem_rdata), .flop_q(flop_q), .pin_out(pin_out), .pin_oe(pin_oe),
      .flop_init_active(flop_init_active), .float_active(float_active),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
   );
   pad_load pads (.drv(pin_out), .oe(pin_oe), .pad(pad));
   always #2.5 aclk = ~aclk;
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic give_up(input int n);
      if (n >= 40) begin
         error_cnt++;
         complete_run();
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge aclk);
   endtask
   // write and read hold each channel until its own handshake edge
   // bready and rready stay high between transfers, so no call lowers and raises them in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done  = 1'b0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_awready && !aw_done) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready && !w_done) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
         if (s_axi_bvalid)
            break;
      end
      give_up(n);
      chk($sformatf("bresp %h", a), s_axi_bresp, er);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      int n;
      logic ar_done;
      ar_done = 1'b0;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_arready && !ar_done) begin
            ar_done = 1'b1;
            s_axi_arvalid <= 1'b0;
         end
         if (s_axi_rvalid)
            break;
      end
      give_up(n);
      chk($sformatf("rresp %h", a), s_axi_rresp, er);
      chk($sformatf("rdata %h", a), s_axi_rdata, exp);
      // arvalid fell at this edge; let one pass before the next call raises it
      @(posedge aclk);
   endtask
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {init_pin, float_pin, user_node, mem_we, mem_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {flop_d, mem_waddr, mem_raddr, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      // ctrl image, init pin, float pin, node, expected init, expected float
      tbl = '{{9'h000, 5'b10010}, {9'h080, 5'b00010}, {9'h080, 5'b10000}, {9'h100, 5'b00110},
              {9'h000, 5'b01001}, {9'h010, 5'b00001}, {9'h020, 5'b00101}, {9'h026, 5'b00100},
              {9'h040, 5'b00010}, {9'h008, 5'b00001}};
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`ADDR_CTRL, 32'h0, `RESP_OKAY);
      wr(8'h3c, 32'h1, `RESP_SLVERR);
      rd(8'h3c, 32'h0, `RESP_SLVERR);
      rd(`ADDR_MEM_ADDR, 32'h0, `RESP_OKAY);
      wr(`ADDR_STATUS, 32'h7, `RESP_OKAY);
      rd(`ADDR_STATUS, 32'h0, `RESP_OKAY);
      wr(`ADDR_FLOP_CFG, 32'ha5, `RESP_OKAY);
      flop_d <= 8'h3c;
      cyc(3);
      chk("flop_q", flop_q, 8'h3c);
      init_pin <= 1'b1;
      cyc(3);
      chk("flop_q", flop_q, 8'ha5);
      flop_d <= 8'hc3;
      cyc(3);
      chk("flop_q", flop_q, 8'ha5);
      rd(`ADDR_STATUS, 32'h1, `RESP_OKAY);
      init_pin <= 1'b0;
      cyc(3);
      chk("flop_q", flop_q, 8'hc3);
      // low nibble forced to its configured value, high nibble keeps following data
      wr(`ADDR_LOCAL_CLR, 32'h0f, `RESP_OKAY);
      cyc(2);
      chk("flop_q", flop_q, 8'hc5);
      wr(`ADDR_LOCAL_CLR, 32'h0, `RESP_OKAY);
      for (int i = 0; i < 10; i++) begin
         wr(`ADDR_CTRL, {23'h0, tbl[i][13:5]}, `RESP_OKAY);
         {init_pin, float_pin, user_node} <= tbl[i][4:2];
         cyc(3);
         chk("flop_init_active", flop_init_active, tbl[i][1]);
         chk("float_active", float_active, tbl[i][0]);
      end
      {init_pin, float_pin, user_node} <= 3'b000;
      wr(`ADDR_CTRL, 32'h0, `RESP_OKAY);
      wr(`ADDR_OUT_DATA, 32'h5a, `RESP_OKAY);
      // byte lane 0 strobed off: the low byte must keep its old value
      s_axi_wstrb <= 4'he;
      wr(`ADDR_OUT_DATA, 32'hff, `RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      rd(`ADDR_OUT_DATA, 32'h5a, `RESP_OKAY);
      wr(`ADDR_SCAN_DATA, 32'h3c, `RESP_OKAY);
      cyc(2);
      chk("pad", pad, 8'h5a);
      float_pin <= 1'b1;
      cyc(3);
      chk("pin_oe", pin_oe, 8'h00);
      chk("pad", pad, 8'h00);
      wr(`ADDR_CTRL, 32'h6, `RESP_OKAY);
      cyc(2);
      chk("pad", pad, 8'h3c);
      float_pin <= 1'b0;
      wr(`ADDR_CTRL, 32'h1, `RESP_OKAY);
      rd(`ADDR_STATUS, 32'h1, `RESP_OKAY);
      wr(`ADDR_CTRL, 32'h0, `RESP_OKAY);
      rd(`ADDR_MEM_DATA, 32'h0, `RESP_OKAY);
      wr(`ADDR_MEM_INIT, 32'hbeef, `RESP_OKAY);
      rd(`ADDR_MEM_DATA, 32'h0, `RESP_OKAY);
      wr(`ADDR_CTRL, 32'h1, `RESP_OKAY);
      wr(`ADDR_CTRL, 32'h0, `RESP_OKAY);
      rd(`ADDR_MEM_DATA, 32'hbeef, `RESP_OKAY);
      mem_waddr <= 4'h3;
      mem_raddr <= 4'h3;
      mem_we    <= 1'b1;
      @(posedge aclk);
      mem_we <= 1'b0;
      cyc(2);
      chk("mem_rdata", mem_rdata, 1'b0);
      // data offered with write enable low must not land
      mem_waddr <= 4'h4;
      mem_wdata <= 1'b1;
      init_pin  <= 1'b1;
      cyc(3);
      init_pin <= 1'b0;
      rd(`ADDR_MEM_DATA, 32'hbee7, `RESP_OKAY);
      complete_run();
   end
endmodule
